// File: design/bss_top.sv
// Control sequencer of a low-frequency base station: phases, mode register,
// diagnostic byte, carrier divider and serial result output.
// Assumes host_control_line is synchronous to clk; rst_n may assert asynchronously.
// Functional notes
// - Clocked mode leaves charge at 3 ms, diag sent
// - Low edge in read ends phase after 0.9 ms
// - Still low after delay: Idle, then charge
// - High after delay: Idle; 100 ms idle sleeps
// - Low edge wakes from Sleep, 2 ms delay
// - Undefined state falls back to Idle
// - Default mode: register zero, low starts charge
// - Line high after charge starts read phase
// - Programmed read-only mode behaves as default
// - Write phase keys carrier from control line
// - After write, charge again, then read
// - Lead configuration bit is not stored
// - Divider select field decodes to factor
// - Auto select loads measured resonance count
// - Bit 5 selects clocked output transfer
// - Bit 6 selects threshold source
// - Bit 7 requests test byte and modes
// - Phase times count from state entry
// - Sequencer enables demodulator and diagnosis
// - Diag byte at 2 ms: af or ff
// - Read ends on low line or 20 ms
// - Clocked transfer: high ready, eight falls
// - Default divider factor is 119
`timescale 1ns/100ps
`include "bss_consts.svh"
`default_nettype none
module bss_top #(
	parameter int T_WAKE  = `BSS_T_WAKE_NS / `BSS_CLK_NS,
	parameter int T_IDLE  = `BSS_T_IDLE_NS / `BSS_CLK_NS,
	parameter int T_DIAG  = `BSS_T_DIAG_NS / `BSS_CLK_NS,
	parameter int T_SYNCX = `BSS_T_SYNC_EXIT_NS / `BSS_CLK_NS,
	parameter int T_READ  = `BSS_T_READ_NS / `BSS_CLK_NS,
	parameter int T_RXEND = `BSS_T_RXEND_NS / `BSS_CLK_NS,
	parameter int T_BIT1  = `BSS_T_BIT1_NS / `BSS_CLK_NS,
	parameter int T_CHG   = `BSS_T_CHG_MIN_NS / `BSS_CLK_NS,
	parameter int T_BAUD  = `BSS_T_BAUD_NS / `BSS_CLK_NS
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       host_control_line,
	input  wire logic       write_mode_select,
	input  wire logic       antenna_ok,
	input  wire logic       driver_shutdown,
	input  wire logic       meas_valid,
	input  wire logic [6:0] meas_count,
	input  wire logic       rx_byte_valid,
	input  wire logic [7:0] rx_byte,
	output logic            rx_byte_ready,
	output logic            serial_result_out,
	output logic            carrier_out,
	output logic            demod_enable,
	output logic            diag_enable,
	output logic [6:0]      divider_factor,
	output logic [7:0]      rx_threshold,
	output logic            clocked_output_select,
	output logic            threshold_source_select,
	output logic            test_mode_req
);
	localparam bss_pkg::bss_tmr_t L_WAKE  = bss_pkg::bss_tmr_t'(T_WAKE - 1);
	localparam bss_pkg::bss_tmr_t L_IDLE  = bss_pkg::bss_tmr_t'(T_IDLE - 1);
	localparam bss_pkg::bss_tmr_t L_DIAG  = bss_pkg::bss_tmr_t'(T_DIAG - 1);
	localparam bss_pkg::bss_tmr_t L_SYNCX = bss_pkg::bss_tmr_t'(T_SYNCX - 1);
	localparam bss_pkg::bss_tmr_t L_READ  = bss_pkg::bss_tmr_t'(T_READ - 1);
	localparam bss_pkg::bss_tmr_t L_RXEND = bss_pkg::bss_tmr_t'(T_RXEND - 1);
	localparam bss_pkg::bss_tmr_t L_BIT1  = bss_pkg::bss_tmr_t'(T_BIT1);
	localparam bss_pkg::bss_tmr_t L_CHG   = bss_pkg::bss_tmr_t'(T_CHG - 1);

	logic                 rst_q_ff, rst_s_n;
	bss_pkg::bss_state_e  st_ff, nxt_st;
	bss_pkg::bss_tmr_t    tmr_ff, nxt_tmr, lo_ff, nxt_lo;
	logic [7:1]           cfg_ff, nxt_cfg;
	logic [7:0]           bits_ff, nxt_bits;
	logic [2:0]           nbit_ff, nxt_nbit;
	logic                 line_ff, force_ff, nxt_force, wr_done_ff, nxt_wr_done;
	logic                 pend_ff, nxt_pend, done_ff, nxt_done;
	logic [6:0]           meas_ff, nxt_meas, div_ff, nxt_div, fac_ff;
	logic                 meas_ok_ff, nxt_meas_ok, ph_ff, nxt_ph, car_ff, nxt_car;
	logic [7:0]           thr_ff, nxt_thr, fifo_din;
	logic                 fall, rise, sync_m, fifo_vin, fifo_rdy, fifo_empty, enc_busy;
	bss_byte_if           enc_if ();

	// ==========================================================
	// Reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q_ff <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_q_ff <= 1'b1;
			rst_s_n <= rst_q_ff;
		end
	end

	function automatic logic [6:0] dec_factor(input logic [3:0] sel, input logic [6:0] meas,
		input logic ok);
		if (sel == `BSS_SEL_114) begin
			dec_factor = `BSS_DIV_114;
		end else if (sel == `BSS_SEL_115) begin
			dec_factor = `BSS_DIV_115;
		end else if (sel == `BSS_SEL_124) begin
			dec_factor = `BSS_DIV_124;
		end else if (sel == `BSS_SEL_AUTO && ok) begin
			dec_factor = meas;
		end else begin
			dec_factor = `BSS_DIV_119;   // Default and both 119 codes
		end
	endfunction : dec_factor

	// ==========================================================
	// Line edges and mode bits
	assign fall = line_ff && !host_control_line;
	assign rise = !line_ff && host_control_line;
	assign sync_m = cfg_ff[`BSS_CFG_SYNC];
	assign clocked_output_select = sync_m;
	assign threshold_source_select = cfg_ff[`BSS_CFG_THR_SRC];
	assign test_mode_req = cfg_ff[`BSS_CFG_TEST];
	assign demod_enable = (st_ff == bss_pkg::ST_READ) || (st_ff == bss_pkg::ST_WRITE);
	assign diag_enable = (st_ff == bss_pkg::ST_CHARGE);
	assign divider_factor = fac_ff;
	assign rx_threshold = thr_ff;
	assign carrier_out = car_ff;

	// ==========================================================
	// Sequencer next state
	always_comb begin
		nxt_st = st_ff;
		nxt_cfg = cfg_ff;
		nxt_bits = bits_ff;
		nxt_nbit = nbit_ff;
		nxt_force = force_ff;
		nxt_wr_done = wr_done_ff;
		nxt_lo = host_control_line ? '0 : lo_ff + 1'b1;
		case (st_ff)
			bss_pkg::ST_SLEEP: if (fall) begin
				nxt_st = bss_pkg::ST_WAKE;
			end
			bss_pkg::ST_WAKE: if (tmr_ff == L_WAKE) begin
				nxt_st = host_control_line ? bss_pkg::ST_IDLE : bss_pkg::ST_CHARGE;
			end
			bss_pkg::ST_IDLE: if (force_ff) begin
				nxt_st = bss_pkg::ST_CHARGE;
				nxt_force = 1'b0;
			end else if (fall) begin
				nxt_st = bss_pkg::ST_PROG;
				nxt_nbit = '0;
			end else if (tmr_ff == L_IDLE) begin
				nxt_st = bss_pkg::ST_SLEEP;
			end
			// short lows are bits, a long low starts charge
			bss_pkg::ST_PROG: if (!host_control_line && lo_ff == L_CHG) begin
				nxt_st = bss_pkg::ST_CHARGE;
			end else if (rise) begin
				nxt_bits = {(lo_ff >= L_BIT1), bits_ff[7:1]};
				nxt_nbit = nbit_ff + 3'h1;
				if (nbit_ff == `BSS_NBITS_LAST) begin
					nxt_cfg = nxt_bits[7:1];
				end
			end else if (tmr_ff == L_IDLE) begin
				nxt_st = bss_pkg::ST_SLEEP;
			end
			bss_pkg::ST_CHARGE: if (sync_m ? (tmr_ff >= L_SYNCX && done_ff && fifo_empty
				&& !enc_busy && host_control_line) : rise) begin
				if (write_mode_select && !wr_done_ff) begin
					nxt_st = bss_pkg::ST_WRITE;
					nxt_wr_done = 1'b1;
				end else begin
					nxt_st = bss_pkg::ST_READ;
					nxt_wr_done = 1'b0;
				end
			end
			bss_pkg::ST_WRITE: if (!host_control_line && lo_ff == L_CHG) begin
				nxt_st = bss_pkg::ST_CHARGE;
			end
			bss_pkg::ST_READ: if (fall && !(sync_m && enc_busy)) begin
				nxt_st = bss_pkg::ST_RXEND;
			end else if (tmr_ff == L_READ) begin
				nxt_st = bss_pkg::ST_IDLE;
			end
			bss_pkg::ST_RXEND: if (tmr_ff == L_RXEND) begin
				nxt_st = bss_pkg::ST_IDLE;
				nxt_force = !host_control_line;
			end
			default: nxt_st = bss_pkg::ST_IDLE;
		endcase
		nxt_tmr = (nxt_st != st_ff) ? '0 : tmr_ff + 1'b1;
	end

	// ==========================================================
	// Diagnostic byte and FIFO feed
	always_comb begin
		nxt_pend = pend_ff;
		nxt_done = done_ff;
		if (st_ff != bss_pkg::ST_CHARGE) begin
			nxt_done = 1'b0;
		end else if (tmr_ff == L_DIAG) begin
			nxt_pend = 1'b1;
		end
		if (pend_ff && fifo_rdy) begin
			nxt_pend = 1'b0;
			nxt_done = 1'b1;
		end
		fifo_vin = pend_ff || ((st_ff == bss_pkg::ST_READ) && rx_byte_valid);
		fifo_din = pend_ff ? ((antenna_ok && !driver_shutdown) ? `BSS_DIAG_OK : `BSS_DIAG_FAIL)
			: ~rx_byte;
		rx_byte_ready = (st_ff == bss_pkg::ST_READ) && !pend_ff && fifo_rdy;
	end

	// ==========================================================
	// Carrier divider, factor and threshold
	always_comb begin
		nxt_meas = meas_valid ? meas_count : meas_ff;
		nxt_meas_ok = meas_ok_ff || meas_valid;
		nxt_div = (div_ff >= fac_ff - 7'h01) ? '0 : div_ff + 7'h01;
		nxt_ph = (div_ff >= fac_ff - 7'h01) ? !ph_ff : ph_ff;
		// carrier keyed by line in write
		nxt_car = ph_ff && ((st_ff == bss_pkg::ST_CHARGE)
			|| ((st_ff == bss_pkg::ST_WRITE) && host_control_line));
		nxt_thr = threshold_source_select ?
			{1'b0, dec_factor(cfg_ff[`BSS_CFG_SEL_HI:`BSS_CFG_SEL_LO], meas_ff, meas_ok_ff)}
			+ `BSS_THR_OFS : {1'b0, meas_ff} + `BSS_THR_OFS;
	end

	// ==========================================================
	// State registers
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			st_ff <= bss_pkg::ST_SLEEP;
			tmr_ff <= '0;
			lo_ff <= '0;
			cfg_ff <= `BSS_CFG_RESET;   // cleared at reset
			bits_ff <= '0;
			nbit_ff <= '0;
			line_ff <= 1'b1;
			force_ff <= 1'b0;
			wr_done_ff <= 1'b0;
			pend_ff <= 1'b0;
			done_ff <= 1'b0;
			meas_ff <= `BSS_DIV_119;
			meas_ok_ff <= 1'b0;
			div_ff <= '0;
			ph_ff <= 1'b0;
			car_ff <= 1'b0;
			fac_ff <= `BSS_DIV_119;
			thr_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			tmr_ff <= nxt_tmr;
			lo_ff <= nxt_lo;
			cfg_ff <= nxt_cfg;
			bits_ff <= nxt_bits;
			nbit_ff <= nxt_nbit;
			line_ff <= host_control_line;
			force_ff <= nxt_force;
			wr_done_ff <= nxt_wr_done;
			pend_ff <= nxt_pend;
			done_ff <= nxt_done;
			meas_ff <= nxt_meas;
			meas_ok_ff <= nxt_meas_ok;
			div_ff <= nxt_div;
			ph_ff <= nxt_ph;
			car_ff <= nxt_car;
			fac_ff <= dec_factor(cfg_ff[`BSS_CFG_SEL_HI:`BSS_CFG_SEL_LO], meas_ff, meas_ok_ff);
			thr_ff <= nxt_thr;
		end
	end

	// ==========================================================
	// Byte buffer and serial encoder
	bss_fifo #(.W(8), .D(16)) u_fifo (
		.clk      (clk),
		.rst_s_n  (rst_s_n),
		.in_valid (fifo_vin),
		.in_ready (fifo_rdy),
		.in_data  (fifo_din),
		.out_if   (enc_if.src),
		.empty    (fifo_empty)
	);
	bss_encoder #(.T_BIT(T_BAUD)) u_enc (
		.clk       (clk),
		.rst_s_n   (rst_s_n),
		.sync_mode (sync_m),
		.line_in   (host_control_line),
		.line_fall (fall),
		.in_if     (enc_if.snk),
		.ser_out   (serial_result_out),
		.busy      (enc_busy)
	);

	// ==========================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_s_n);
	AST_WAKE: assert property (st_ff == bss_pkg::ST_SLEEP && fall
		|=> st_ff == bss_pkg::ST_WAKE) else $error("No wake on falling edge");
	AST_FORCE_DIAG: assert property (st_ff == bss_pkg::ST_RXEND && tmr_ff == L_RXEND
		&& !host_control_line |=> st_ff == bss_pkg::ST_IDLE ##1 st_ff == bss_pkg::ST_CHARGE)
		else $error("Low after delay did not reach charge");
	AST_RXEND_HOLD: assert property (st_ff == bss_pkg::ST_RXEND && tmr_ff < L_RXEND
		|=> st_ff == bss_pkg::ST_RXEND) else $error("Receive end left early");
	AST_IDLE_SLEEP: assert property (st_ff == bss_pkg::ST_IDLE && !force_ff && !fall
		&& tmr_ff == L_IDLE |=> st_ff == bss_pkg::ST_SLEEP) else $error("Idle did not sleep");
	AST_RX_TIMEOUT: assert property (st_ff == bss_pkg::ST_READ && tmr_ff == L_READ
		&& !fall |=> st_ff == bss_pkg::ST_IDLE) else $error("Read not ended at 20 ms");
	AST_DIAG_TIME: assert property ($rose(pend_ff)
		|-> $past(st_ff) == bss_pkg::ST_CHARGE && $past(tmr_ff) == L_DIAG)
		else $error("Diag late");
	AST_SYNC_EXIT: assert property ($fell(st_ff == bss_pkg::ST_CHARGE) && $past(sync_m)
		|-> $past(tmr_ff) >= L_SYNCX && $past(done_ff)) else $error("Clocked charge exit early");
	AST_READ_ENTRY: assert property (st_ff == bss_pkg::ST_CHARGE && !sync_m && rise
		&& !write_mode_select |=> st_ff == bss_pkg::ST_READ) else $error("Read not entered");
	AST_FACTOR: assert property (cfg_ff[`BSS_CFG_SEL_HI:`BSS_CFG_SEL_LO] == `BSS_SEL_114
		&& $stable(cfg_ff) |-> divider_factor == `BSS_DIV_114)
		else $error("Factor 114 not decoded");
	COV_READ: cover property (st_ff == bss_pkg::ST_CHARGE ##1 st_ff == bss_pkg::ST_READ);
	COV_WRITE: cover property (st_ff == bss_pkg::ST_WRITE ##1 st_ff == bss_pkg::ST_CHARGE);
	COV_SLEEP: cover property (st_ff == bss_pkg::ST_IDLE ##1 st_ff == bss_pkg::ST_SLEEP);
	COV_FORCE: cover property (force_ff && st_ff == bss_pkg::ST_IDLE);
endmodule : bss_top
`default_nettype wire

// File: design/bss_consts.svh
// Constants of the base station control sequencer: timings, field positions, codes.
// Assumes a 250 MHz core clock; included by the bss_top and bss_encoder design files of the block.
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH
// ==========================================================
// Clock and phase timing (ns)
`define BSS_CLK_NS        4
`define BSS_T_WAKE_NS     2000000
`define BSS_T_IDLE_NS     100000000
`define BSS_T_DIAG_NS     2000000
`define BSS_T_SYNC_EXIT_NS 3000000
`define BSS_T_READ_NS     20000000
`define BSS_T_RXEND_NS    900000
`define BSS_T_BIT1_NS     50000
`define BSS_T_CHG_MIN_NS  1000000
`define BSS_T_BAUD_NS     64000
// ==========================================================
// Mode configuration fields (bit 0 lead bit is not stored)
`define BSS_CFG_SEL_HI    4
`define BSS_CFG_SEL_LO    1
`define BSS_CFG_SYNC      5
`define BSS_CFG_THR_SRC   6
`define BSS_CFG_TEST      7
`define BSS_CFG_RESET     7'h00
`define BSS_NBITS_LAST    3'h7
// ==========================================================
// Divider select codes and factors
`define BSS_SEL_DEF_A     4'h0
`define BSS_SEL_DEF_B     4'h6
`define BSS_SEL_114       4'h1
`define BSS_SEL_115       4'h2
`define BSS_SEL_124       4'hb
`define BSS_SEL_AUTO      4'hf
`define BSS_DIV_119       7'h77
`define BSS_DIV_114       7'h72
`define BSS_DIV_115       7'h73
`define BSS_DIV_124       7'h7c
`define BSS_THR_OFS       8'h05
// ==========================================================
// Diagnostic bytes and serial framing
`define BSS_DIAG_OK       8'haf
`define BSS_DIAG_FAIL     8'hff
`define BSS_ENC_SYNC_LAST 4'h8
`define BSS_ENC_ASYNC_LAST 4'h9
`endif

// File: design/bss_pkg.sv
// Types shared by the base station control sequencer.
// Assumes nothing of its surroundings.
package bss_pkg;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_SLEEP, ST_WAKE, ST_IDLE, ST_PROG, ST_CHARGE, ST_WRITE, ST_READ, ST_RXEND
	} bss_state_e;
	typedef logic [24:0] bss_tmr_t;
	typedef logic [7:0]  bss_byte_t;
endpackage : bss_pkg

// File: design/bss_byte_if.sv
// Byte stream carrier between the FIFO and the serial encoder.
// Assumes one clock domain; valid/ready handshake, transfer when both high.
`timescale 1ns/100ps
`default_nettype none
interface bss_byte_if;
	logic              valid;
	logic              ready;
	bss_pkg::bss_byte_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : bss_byte_if
`default_nettype wire

// File: design/bss_fifo.sv
// Byte FIFO between sequencer sources and the serial encoder.
// Assumes synchronous active-low reset already released cleanly.
`timescale 1ns/100ps
`default_nettype none
module bss_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_s_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	bss_byte_if.src           out_if,
	output logic              empty
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
	logic [AW:0]   cnt_ff, nxt_cnt;
	logic          push, pop;
	// ==========================================================
	// Handshake and pointer update
	always_comb begin
		in_ready = (cnt_ff != (AW + 1)'(D));
		empty = (cnt_ff == '0);
		out_if.valid = !empty;
		out_if.data = mem[rp_ff];
		push = in_valid && in_ready;
		pop = out_if.valid && out_if.ready;
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
		nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
	end
	// Pointer registers
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end
	// Storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_ff] <= in_data;
		end
	end
endmodule : bss_fifo
`default_nettype wire

// File: design/bss_encoder.sv
// Serial result encoder: framed asynchronous or host-clocked byte output.
// Assumes the host clocks synchronous bits with falling edges of its control line.
`timescale 1ns/100ps
`include "bss_consts.svh"
`default_nettype none
module bss_encoder #(
	parameter int T_BIT = `BSS_T_BAUD_NS / `BSS_CLK_NS
) (
	input  wire logic clk,
	input  wire logic rst_s_n,
	input  wire logic sync_mode,
	input  wire logic line_in,
	input  wire logic line_fall,
	bss_byte_if.snk   in_if,
	output logic      ser_out,
	output logic      busy
);
	localparam bss_pkg::bss_tmr_t L_BIT = bss_pkg::bss_tmr_t'(T_BIT - 1);
	logic [9:0]        sh_ff, nxt_sh;
	logic [3:0]        cnt_ff, nxt_cnt;
	bss_pkg::bss_tmr_t tb_ff, nxt_tb;
	logic              act_ff, nxt_act, ser_ff;
	assign in_if.ready = !act_ff;
	assign ser_out = ser_ff;
	assign busy = act_ff;
	// ==========================================================
	// Frame: start high, 8 data LSB first, stop low; sync shows ready high
	always_comb begin
		nxt_sh = sh_ff;
		nxt_cnt = cnt_ff;
		nxt_tb = tb_ff;
		nxt_act = act_ff;
		if (!act_ff) begin
			if (in_if.valid) begin
				nxt_act = 1'b1;
				nxt_sh = {1'b0, in_if.data, 1'b1};
				nxt_cnt = '0;
				nxt_tb = '0;
			end
		end else if (sync_mode) begin
			if (cnt_ff == `BSS_ENC_SYNC_LAST) begin
				nxt_act = !line_in;       // Release once host clock ends high
				if (line_in) begin
					nxt_sh = '0;
				end
			end else if (line_fall) begin
				nxt_sh = {1'b0, sh_ff[9:1]};
				nxt_cnt = cnt_ff + 4'h1;
			end
		end else if (tb_ff == L_BIT) begin
			nxt_tb = '0;
			nxt_sh = {1'b0, sh_ff[9:1]};
			nxt_cnt = cnt_ff + 4'h1;
			nxt_act = (cnt_ff != `BSS_ENC_ASYNC_LAST);
		end else begin
			nxt_tb = tb_ff + 1'b1;
		end
	end
	// Encoder registers
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			sh_ff <= '0;
			cnt_ff <= '0;
			tb_ff <= '0;
			act_ff <= 1'b0;
			ser_ff <= 1'b0;
		end else begin
			sh_ff <= nxt_sh;
			cnt_ff <= nxt_cnt;
			tb_ff <= nxt_tb;
			act_ff <= nxt_act;
			ser_ff <= nxt_act & nxt_sh[0];
		end
	end
endmodule : bss_encoder
`default_nettype wire

// File: sim/bss_host_model.sv
// Host side model: owns the control line and its pulse coding.
// Assumes tasks are called from the bench after reset is released.
`timescale 1ns/100ps
`default_nettype none
module bss_host_model (
	input  wire logic clk,
	output logic      host_control_line
);
	// ==========================================================
	// Line drive
	// Line idles high at start
	initial host_control_line = 1'b1;
	// Drive a level for n cycles from the next edge
	task automatic drive(input logic v, input int n);
		@(posedge clk);
		host_control_line <= v;
		repeat (n - 1) @(posedge clk);
	endtask : drive
	task automatic wake();
		drive(1'b0, 1);
		drive(1'b1, 50);
	endtask : wake
	task automatic load_cfg(input logic [7:0] cfg);
		for (int i = 0; i < 8; i++) begin
			drive(1'b0, cfg[i] ? 12 : 3);
			drive(1'b1, 4);
		end
	endtask : load_cfg
endmodule : bss_host_model
`default_nettype wire

// File: sim/bss_top_bench.sv
// Self-checking bench of the sequencer top with shortened phase times.
// Assumes the host model drives the control line; 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module bss_top_bench;
	localparam int TD = 40, TR = 300, TX = 20, TB = 4;
	logic       clk, rst_n, wms, aok, dsh, mv, rxv, rdy, so, dem, dge, css, tss, tmq, car;
	logic [6:0] mc, dvf;
	logic [7:0] rxb, thr, v;
	wire logic  line;
	int         failures, n_checks, n;

	// ==========================================================
	// Design and host
	bss_top #(.T_WAKE(40), .T_IDLE(400), .T_DIAG(TD), .T_SYNCX(60), .T_READ(TR),
		.T_RXEND(TX), .T_BIT1(8), .T_CHG(30), .T_BAUD(TB)) u_dut (
		.clk(clk), .rst_n(rst_n), .host_control_line(line), .write_mode_select(wms),
		.antenna_ok(aok), .driver_shutdown(dsh), .meas_valid(mv), .meas_count(mc),
		.rx_byte_valid(rxv), .rx_byte(rxb), .rx_byte_ready(rdy), .serial_result_out(so),
		.carrier_out(car), .demod_enable(dem), .diag_enable(dge), .divider_factor(dvf),
		.rx_threshold(thr), .clocked_output_select(css), .threshold_source_select(tss),
		.test_mode_req(tmq));
	bss_host_model u_host (.clk(clk), .host_control_line(line));

	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	// Bounded wait for a level, cycles counted
	task automatic wait_for(ref logic s, input logic lvl, output int c);
		c = 0;
		while (s !== lvl && c < 3000) begin
			tick(1);
			c++;
		end
	endtask : wait_for
	// Capture one framed byte, sampling mid bit
	task automatic get_byte(output logic [7:0] b);
		wait_for(so, 1'b1, n);
		tick(TB + TB / 2);
		for (int k = 0; k < 8; k++) begin
			b[k] = so;
			tick(TB);
		end
	endtask : get_byte
	// Offer one received byte until taken
	task automatic send_rx(input logic [7:0] b);
		int   i;
		logic ok;
		i = 0;
		@(posedge clk);
		rxv <= 1'b1;
		rxb <= b;
		// Ready judged between edges, offer held through the taking edge
		do begin
			@(negedge clk);
			ok = (rdy === 1'b1);
			@(posedge clk);
		end while (!ok && ++i < 200);
		rxv <= 1'b0;
	endtask : send_rx

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		chk("divider", 8'h77, {1'b0, dvf});
		chk("cfg", 8'h00, {5'h00, tmq, tss, css});
		chk("phase", 8'h00, {6'h00, dem, dge});
		$display("test reset done");
	endtask : test_reset
	task automatic test_program_read();
		u_host.wake();
		u_host.load_cfg(8'h42);
		tick(4);
		chk("divider", 8'h72, {1'b0, dvf});
		chk("sync", 8'h00, {7'h00, css});
		chk("thr_src", 8'h01, {7'h00, tss});
		chk("test", 8'h00, {7'h00, tmq});
		chk("threshold", 8'h77, thr);
		u_host.drive(1'b0, 1);
		wait_for(dge, 1'b1, n);
		chk("charge", 8'h01, {7'h00, dge});
		get_byte(v);
		chk("diag", 8'haf, v);
		u_host.drive(1'b1, 1);
		wait_for(dem, 1'b1, n);
		chk("read", 8'h01, {7'h00, dem});
		send_rx(8'h3c);
		get_byte(v);
		chk("rx_data", 8'hc3, v);
		$display("test program_read done");
	endtask : test_program_read
	task automatic test_rxend_read();
		@(posedge clk);
		dsh <= 1'b1;
		u_host.drive(1'b0, 1);
		tick(2);
		chk("read_end", 8'h00, {7'h00, dem});
		wait_for(dge, 1'b1, n);
		chk("rxend_delay", 8'h01, {7'h00, n >= TX - 2 && n <= TX + 4});
		get_byte(v);
		chk("diag", 8'hff, v);
		u_host.drive(1'b1, 1);
		wait_for(dem, 1'b1, n);
		wait_for(dem, 1'b0, n);
		chk("read_time", 8'h01, {7'h00, n >= TR - 4 && n <= TR + 2});
		$display("test rxend_read done");
	endtask : test_rxend_read
	// Auto factor, clocked diag byte, write keying, back to charge
	task automatic test_sync_write();
		@(posedge clk);
		dsh <= 1'b0;
		wms <= 1'b1;
		mv <= 1'b1;
		mc <= 7'h75;
		@(posedge clk);
		mv <= 1'b0;
		u_host.load_cfg(8'h3e);
		tick(4);
		chk("auto_div", 8'h75, {1'b0, dvf});
		chk("sync", 8'h01, {7'h00, css});
		chk("auto_thr", 8'h7a, thr);
		u_host.drive(1'b0, 1);
		wait_for(dge, 1'b1, n);
		u_host.drive(1'b1, 1);
		wait_for(so, 1'b1, n);
		chk("ready", 8'h01, {7'h00, so});
		for (int k = 0; k < 8; k++) begin
			u_host.drive(1'b0, 2);
			#1;
			v[k] = so;
			u_host.drive(1'b1, 2);
		end
		chk("sync_diag", 8'haf, v);
		wait_for(dem, 1'b1, n);
		chk("write", 8'h02, {6'h00, dem, dge});
		wait_for(car, 1'b1, n);
		chk("carrier", 8'h01, {7'h00, car});
		u_host.drive(1'b0, 1);
		tick(2);
		chk("keyed", 8'h00, {7'h00, car});
		wait_for(dge, 1'b1, n);
		chk("recharge", 8'h02, {6'h00, dge, dem});
		$display("test sync_write done");
	endtask : test_sync_write

	// ==========================================================
	// Verdict
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		give_verdict();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		wms = 1'b0;
		aok = 1'b1;
		dsh = 1'b0;
		mv = 1'b0;
		mc = 7'h00;
		rxv = 1'b0;
		rxb = 8'h00;
		failures = 0;
		n_checks = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		tick(4);
		test_reset();
		test_program_read();
		test_rxend_read();
		test_sync_write();
		give_verdict();
	end
endmodule : bss_top_bench
`default_nettype wire
